// ===== src/lpm_controller.sv
// Low-power mode controller: mode state, oscillator and domain sequencing.
//
// What this block does
// [R1] Three voltage ranges cap CPU clock frequency.
// [R2] Flash wait states follow range and frequency.
// [R3] Sleep halts CPU clock; any interrupt resumes.
// [R4] Low-power run: low multispeed RC, regulator low-power.
// [R5] Low-power sleep wakes to Run, regulator on.
// [R6] Stop with calendar: fast clocks off except fast RC on request, slow kept.
// [R7] Stop: wakeup peripheral may request fast RC.
// [R8] Event line wakes Stop within 3.5 us.
// [R9] Stop with calendar accepts all listed sources.
// [R10] Stop without calendar: all oscillators off except fast RC on request.
// [R11] Standby powers core off, always-on kept.
// [R12] Standby with calendar exits within 60 us.
// [R13] Standby without calendar: reset pin, wake pins.
// [R14] Calendar and watchdog not stopped by modes.
// [R16] Wakeup to Run meets per-mode time limits.
// [R17] Fast RC optional in Run, Sleep only.
// [R18] Requested fast RC feeds requester, auto off.
// [R19] Start bit or address match wakes Stop.
// [R20] Explicit mode state, idle-only entry, ordered sequencing.
// [R21] Wake pins synchronised, rising edge only.
`timescale 1ns/1ps
`default_nettype none

module lpm_controller
  import lpm_pkg::*;
(
  // Clock and reset.
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  // CPU side.
  input  wire logic                     cpu_idle_i,
  input  wire logic                     mode_req_i,
  input  wire lpm_req_type              mode_sel_i,
  input  wire logic                     calendar_keep_i,
  input  wire logic [1:0]               range_i,
  input  wire logic [15:0]              cpu_khz_i,
  input  wire logic                     irq_pending_i,
  input  wire logic                     lprun_exit_i,
  // Software oscillator choices for Run and Sleep.
  input  wire lpm_osc_type              osc_sw_i,
  // Wake sources and the fast RC request.
  input  wire lpm_wake_type             wake_i,
  input  wire logic [NUM_WAKE_PINS-1:0] wake_pins_i,
  input  wire logic                     reset_pin_i,
  input  wire logic                     independent_watchdog_rst_i,
  input  wire logic                     fast_rc_req_i,
  // Controls.
  output lpm_state_type                 mode_o,
  output lpm_osc_type                   osc_en_o,
  output lpm_dom_type                   dom_o,
  output logic                          fast_rc_to_periph_o,
  output logic                          flash_ws_o,
  output logic                          freq_err_o,
  output logic                          wake_irq_o,
  output logic                          standby_reset_o,
  output logic                          calendar_run_o
);

  lpm_state_type state;
  lpm_state_type next_state;
  lpm_state_type return_state;
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] next_wake_cnt;
  logic cal_kept;
  logic [NUM_WAKE_PINS-1:0] pin_meta;
  logic [NUM_WAKE_PINS-1:0] pin_sync;
  logic [NUM_WAKE_PINS-1:0] pin_last;
  logic pin_rise;
  logic stop_wake;
  logic standby_wake;
  logic any_periph_wake;

  // Two-stage synchroniser per wake pin, then edge detect on stage two.
  genvar g;
  generate
    for (g = 0; g < NUM_WAKE_PINS; g++) begin : g_pin
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
          pin_last[g] <= 1'b0;
        end else begin
          pin_meta[g] <= wake_pins_i[g]; // R21
          pin_sync[g] <= pin_meta[g]; // R21
          pin_last[g] <= pin_sync[g];
        end
      end
    end
  endgenerate

  // A high level held through entry does not count; only a new rising edge.
  assign pin_rise = |(pin_sync & ~pin_last); // R21

  assign any_periph_wake = wake_i.serial_start_bit
                         | wake_i.lowpower_serial_port_start
                         | wake_i.two_wire_addr_match
                         | wake_i.lowpower_timer_wake; // R19

  always_comb begin
    stop_wake = (|wake_i.gpio_events) | any_periph_wake; // R10
    if (cal_kept) begin
      stop_wake = stop_wake | wake_i.calendar_alarm_a
                | wake_i.calendar_alarm_b | wake_i.calendar_tamper
                | wake_i.calendar_timestamp | wake_i.calendar_wake; // R9
    end
  end

  always_comb begin
    standby_wake = reset_pin_i | pin_rise; // R13
    if (cal_kept) begin
      standby_wake = standby_wake | independent_watchdog_rst_i
                   | wake_i.calendar_alarm_a | wake_i.calendar_alarm_b
                   | wake_i.calendar_tamper | wake_i.calendar_timestamp
                   | wake_i.calendar_wake; // R12
    end
  end

  // Mode sequencer.
  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    unique case (state)
      LPM_RUN: begin
        if (mode_req_i && cpu_idle_i) begin // R20
          unique case (mode_sel_i)
            LPM_REQ_SLEEP:   next_state = LPM_SLEEP;
            LPM_REQ_LPRUN:   next_state = LPM_LPRUN;
            LPM_REQ_LPSLEEP: next_state = LPM_LPSLEEP;
            LPM_REQ_STOP:    next_state = LPM_STOP_ENTER;
            LPM_REQ_STANDBY: next_state = LPM_STANDBY_ENTER;
            default:         next_state = LPM_RUN;
          endcase
        end
      end
      LPM_SLEEP: begin
        if (irq_pending_i) begin // R3
          next_state = LPM_WAKE;
          next_wake_cnt = CNT_W'(SLEEP_WAKE_CYC - 1); // R16
        end
      end
      LPM_LPRUN: begin
        if (lprun_exit_i || irq_pending_i) begin
          next_state = LPM_WAKE;
          next_wake_cnt = CNT_W'(LPRUN_WAKE_CYC - 1); // R16
        end
      end
      LPM_LPSLEEP: begin
        if (irq_pending_i) begin // R5
          next_state = LPM_WAKE;
          next_wake_cnt = CNT_W'(LPSLEEP_WAKE_CYC - 1); // R16
        end
      end
      // Clocks stop first, then regulator drops: one cycle apart.
      LPM_STOP_ENTER: next_state = LPM_STOP; // R20
      LPM_STOP: begin
        if (stop_wake) begin // R8
          next_state = LPM_WAKE;
          next_wake_cnt = CNT_W'(STOP_WAKE_CYC - 1); // R8
        end
      end
      LPM_STANDBY_ENTER: next_state = LPM_STANDBY; // R20
      LPM_STANDBY: begin
        if (standby_wake) begin
          next_state = LPM_WAKE;
          next_wake_cnt = CNT_W'(STANDBY_WAKE_CYC - 1); // R12
        end
      end
      LPM_WAKE: begin
        if (wake_cnt == '0) begin
          next_state = LPM_RUN;
        end else begin
          next_wake_cnt = wake_cnt - 1'b1;
        end
      end
      default: next_state = LPM_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= LPM_RUN;
      wake_cnt <= '0;
    end else begin
      state <= next_state; // R20
      wake_cnt <= next_wake_cnt;
    end
  end

  // Calendar choice is captured when a deep mode is entered.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_kept <= 1'b0;
      return_state <= LPM_RUN;
    end else if (state == LPM_RUN && mode_req_i && cpu_idle_i) begin
      cal_kept <= calendar_keep_i;
      return_state <= LPM_RUN;
    end
  end

  // Oscillator and domain controls per mode.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_en_o <= '0;
      dom_o <= '{cpu_clk: 1'b1, core_clks: 1'b1, regulator_lp: 1'b0,
                 core_power: 1'b1, retain: 1'b1};
      fast_rc_to_periph_o <= 1'b0;
    end else begin
      fast_rc_to_periph_o <= 1'b0;
      unique case (next_state)
        LPM_RUN, LPM_WAKE: begin
          osc_en_o <= osc_sw_i; // R17
          dom_o <= '{cpu_clk: (next_state == LPM_RUN), core_clks: 1'b1,
                     regulator_lp: 1'b0, core_power: 1'b1,
                     retain: 1'b1}; // R5
        end
        LPM_SLEEP: begin
          osc_en_o <= osc_sw_i; // R17
          dom_o <= '{cpu_clk: 1'b0, core_clks: 1'b1, regulator_lp: 1'b0,
                     core_power: 1'b1, retain: 1'b1}; // R3
        end
        LPM_LPRUN, LPM_LPSLEEP: begin
          osc_en_o <= '{pll: 1'b0, multispeed_rc_osc: 1'b1,
                        multispeed_low: 1'b1,
                        fast_external_osc: osc_sw_i.fast_external_osc,
                        fast_internal_rc: 1'b0,
                        slow_crystal_osc: osc_sw_i.slow_crystal_osc,
                        slow_internal_rc: osc_sw_i.slow_internal_rc}; // R4
          dom_o <= '{cpu_clk: (next_state == LPM_LPRUN), core_clks: 1'b1,
                     regulator_lp: 1'b1, core_power: 1'b1,
                     retain: 1'b1}; // R4
        end
        LPM_STOP_ENTER, LPM_STOP: begin
          osc_en_o <= '{pll: 1'b0, multispeed_rc_osc: 1'b0,
                        multispeed_low: 1'b0, fast_external_osc: 1'b0,
                        fast_internal_rc: fast_rc_req_i, // R7
                        slow_crystal_osc: cal_kept & osc_sw_i.slow_crystal_osc,
                        slow_internal_rc: cal_kept
                                          & osc_sw_i.slow_internal_rc}; // R6
          fast_rc_to_periph_o <= fast_rc_req_i; // R18
          dom_o <= '{cpu_clk: 1'b0, core_clks: 1'b0,
                     regulator_lp: (next_state == LPM_STOP),
                     core_power: 1'b1, retain: 1'b1}; // R6
        end
        LPM_STANDBY_ENTER, LPM_STANDBY: begin
          osc_en_o <= '{pll: 1'b0, multispeed_rc_osc: 1'b0,
                        multispeed_low: 1'b0, fast_external_osc: 1'b0,
                        fast_internal_rc: 1'b0,
                        slow_crystal_osc: cal_kept & osc_sw_i.slow_crystal_osc,
                        slow_internal_rc: cal_kept
                                          & osc_sw_i.slow_internal_rc}; // R13
          dom_o <= '{cpu_clk: 1'b0, core_clks: 1'b0, regulator_lp: 1'b1,
                     core_power: (next_state == LPM_STANDBY_ENTER),
                     retain: 1'b0}; // R11
        end
        default: begin
          osc_en_o <= osc_sw_i;
          dom_o <= '{cpu_clk: 1'b1, core_clks: 1'b1, regulator_lp: 1'b0,
                     core_power: 1'b1, retain: 1'b1};
        end
      endcase
    end
  end

  // Wakeup interrupt pulse; standby exit reset stays low, as dom_o.retain is set in LPM_WAKE.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_irq_o <= 1'b0;
      standby_reset_o <= 1'b0;
    end else begin
      wake_irq_o <= (state == LPM_STOP) && stop_wake; // R19
      standby_reset_o <= (state == LPM_WAKE) && (next_state == LPM_RUN)
                         && !cal_kept && (return_state == LPM_RUN)
                         && !dom_o.retain; // R11
    end
  end

  // Calendar keeps running whatever the mode; only software stops it.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      calendar_run_o <= 1'b1;
    end else begin
      calendar_run_o <= osc_sw_i.slow_crystal_osc
                        | osc_sw_i.slow_internal_rc; // R14
    end
  end

  // Range limits and wait states; low-power run has its own low cap.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flash_ws_o <= 1'b0;
      freq_err_o <= 1'b0;
      mode_o <= LPM_RUN;
    end else begin
      mode_o <= next_state;
      flash_ws_o <= wait_states(range_i, cpu_khz_i); // R2
      freq_err_o <= (cpu_khz_i > range_limit(range_i))
                    || (state == LPM_LPRUN
                        && 32'(cpu_khz_i) > LP_RUN_MAX_KHZ); // R1
    end
  end

endmodule

`default_nettype wire

// ===== src/lpm_pkg.sv
// Package with the modes, ranges, timing constants and carrier structs.
package lpm_pkg;

  // Clock rate of the controller.
  localparam int unsigned CLK_MHZ = 100;

  // Frequency limits per voltage range, in kHz.
  localparam int unsigned RANGE1_MAX_KHZ = 32000;
  localparam int unsigned RANGE2_MAX_KHZ = 16000;
  localparam int unsigned RANGE3_MAX_KHZ = 4200;
  localparam int unsigned RANGE1_WS_KHZ  = 16000;
  localparam int unsigned RANGE2_WS_KHZ  = 8000;
  localparam int unsigned LP_RUN_MAX_KHZ = 131;

  // Wakeup budgets, in ns and in CPU cycles.
  localparam int unsigned SLEEP_WAKE_CYC   = 6;
  localparam int unsigned LPSLEEP_WAKE_CYC = 7;
  localparam int unsigned LPRUN_WAKE_NS    = 3000;
  localparam int unsigned STOP_WAKE_NS     = 3500;
  localparam int unsigned STANDBY_WAKE_NS  = 60000;
  localparam int unsigned CLK_PERIOD_NS    = 1000 / CLK_MHZ;

  // Longest times round down to whole cycles.
  localparam int unsigned LPRUN_WAKE_CYC   = LPRUN_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned STOP_WAKE_CYC    = STOP_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned STANDBY_WAKE_CYC = STANDBY_WAKE_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_WAKE_PINS = 3;
  localparam int unsigned NUM_GPIO_LINES = 16;

  localparam logic [1:0] RANGE_1 = 2'h1;
  localparam logic [1:0] RANGE_2 = 2'h2;
  localparam logic [1:0] RANGE_3 = 2'h3;

  typedef enum logic [2:0] {
    LPM_REQ_SLEEP,
    LPM_REQ_LPRUN,
    LPM_REQ_LPSLEEP,
    LPM_REQ_STOP,
    LPM_REQ_STANDBY
  } lpm_req_type;

  typedef enum logic [3:0] {
    LPM_RUN,
    LPM_SLEEP,
    LPM_LPRUN,
    LPM_LPSLEEP,
    LPM_STOP_ENTER,
    LPM_STOP,
    LPM_STANDBY_ENTER,
    LPM_STANDBY,
    LPM_WAKE
  } lpm_state_type;

  // Oscillator and domain enables driven out of the controller.
  typedef struct packed {
    logic pll;
    logic multispeed_rc_osc;
    logic multispeed_low;
    logic fast_external_osc;
    logic fast_internal_rc;
    logic slow_crystal_osc;
    logic slow_internal_rc;
  } lpm_osc_type;

  typedef struct packed {
    logic cpu_clk;
    logic core_clks;
    logic regulator_lp;
    logic core_power;
    logic retain;
  } lpm_dom_type;

  // Wake sources from the peripherals.
  typedef struct packed {
    logic [NUM_GPIO_LINES-1:0] gpio_events;
    logic calendar_alarm_a;
    logic calendar_alarm_b;
    logic calendar_tamper;
    logic calendar_timestamp;
    logic calendar_wake;
    logic serial_start_bit;
    logic lowpower_serial_port_start;
    logic two_wire_addr_match;
    logic lowpower_timer_wake;
  } lpm_wake_type;

  // Flash wait states for a range and a CPU frequency in kHz.
  function automatic logic wait_states(input logic [1:0] range,
                                       input logic [15:0] khz);
    logic ws;
    ws = 1'b0;
    if (range == RANGE_1) begin
      ws = (32'(khz) > RANGE1_WS_KHZ);
    end else if (range == RANGE_2) begin
      ws = (32'(khz) > RANGE2_WS_KHZ);
    end
    return ws;
  endfunction

  function automatic logic [15:0] range_limit(input logic [1:0] range);
    logic [15:0] lim;
    lim = 16'(RANGE3_MAX_KHZ);
    if (range == RANGE_1) begin
      lim = 16'(RANGE1_MAX_KHZ);
    end else if (range == RANGE_2) begin
      lim = 16'(RANGE2_MAX_KHZ);
    end
    return lim;
  endfunction

endpackage

// ===== verif/lpm_chk.sv
// Port checker for the low-power mode controller.
`timescale 1ns/1ps
`default_nettype none
module lpm_chk
  import lpm_pkg::*;
(
  // Clock and reset.
  input wire logic          clk_i,
  input wire logic          arst_n_i,
  // Watched inputs.
  input wire logic          cpu_idle_i,
  input wire logic          mode_req_i,
  input wire lpm_req_type   mode_sel_i,
  input wire logic          irq_pending_i,
  input wire lpm_wake_type  wake_i,
  input wire logic          fast_rc_req_i,
  input wire logic          calendar_keep_i,
  // Watched outputs.
  input wire lpm_state_type mode_o,
  input wire lpm_osc_type   osc_en_o,
  input wire lpm_dom_type   dom_o,
  input wire logic          fast_rc_to_periph_o,
  input wire logic          wake_irq_o,
  input wire logic          calendar_run_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic go;
  assign go = mode_req_i & cpu_idle_i;

  entry_gate_a: assert property (
    mode_o == LPM_RUN && !go |=> mode_o == LPM_RUN)
    else $error("Run left without an idle request.");
  sleep_entry_a: assert property (
    mode_o == LPM_RUN && go && mode_sel_i == LPM_REQ_SLEEP
    |=> mode_o == LPM_SLEEP && !dom_o.cpu_clk && dom_o.core_clks)
    else $error("Sleep entry wrong.");
  lprun_osc_a: assert property (
    mode_o == LPM_LPRUN |-> osc_en_o.multispeed_low && dom_o.regulator_lp
    && !osc_en_o.fast_internal_rc)
    else $error("Low-power run clocks wrong.");
  stop_osc_a: assert property (
    mode_o == LPM_STOP |-> !osc_en_o.pll && !osc_en_o.multispeed_rc_osc
    && !osc_en_o.fast_external_osc && !dom_o.core_clks && dom_o.retain)
    else $error("Stop clocks wrong.");
  nocal_osc_a: assert property (
    mode_o == LPM_RUN && go && mode_sel_i == LPM_REQ_STOP && !calendar_keep_i
    |-> ##2 !osc_en_o.slow_crystal_osc && !osc_en_o.slow_internal_rc)
    else $error("Slow source on in Stop without calendar.");
  stby_power_a: assert property (
    mode_o == LPM_STANDBY |-> !dom_o.core_power && !dom_o.retain
    && !osc_en_o.pll && !osc_en_o.multispeed_rc_osc)
    else $error("Standby power wrong.");
  fast_rc_on_a: assert property (
    (mode_o == LPM_STOP && fast_rc_req_i) [*3] |-> fast_rc_to_periph_o)
    else $error("Fast RC not routed on request.");
  fast_rc_off_a: assert property (
    !fast_rc_req_i [*3] |-> !fast_rc_to_periph_o)
    else $error("Fast RC stayed on.");
  sleep_wake_a: assert property (
    mode_o == LPM_SLEEP && irq_pending_i |-> ##[1:8] mode_o == LPM_RUN)
    else $error("Sleep wake too slow.");
  stop_wake_a: assert property (
    mode_o == LPM_STOP && wake_i.gpio_events != '0 |-> ##[0:4] wake_irq_o)
    else $error("Stop wake pulse missing.");
endmodule

bind lpm_controller lpm_chk i_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .cpu_idle_i(cpu_idle_i),
  .mode_req_i(mode_req_i), .mode_sel_i(mode_sel_i),
  .irq_pending_i(irq_pending_i), .wake_i(wake_i),
  .fast_rc_req_i(fast_rc_req_i), .calendar_keep_i(calendar_keep_i),
  .mode_o(mode_o), .osc_en_o(osc_en_o),
  .dom_o(dom_o), .fast_rc_to_periph_o(fast_rc_to_periph_o),
  .wake_irq_o(wake_irq_o), .calendar_run_o(calendar_run_o)
);
`default_nettype wire

// ===== verif/lpm_periph.sv
// Model of the peripherals and wake pins beside the controller.
`timescale 1ns/1ps
`default_nettype none
module lpm_periph
  import lpm_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Bench command: bit 3 asks for fast RC, bits 2:0 pick an event.
  input  wire logic [3:0] src_i,
  // Towards the controller.
  output logic            irq_o,
  output lpm_wake_type    wake_o,
  output logic [2:0]      pins_o,
  output logic            fast_rc_req_o
);
  // Events are held as levels until withdrawn, as a flag stays set until
  // software clears it; a pulse would hide a controller that polls late.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
      wake_o <= '0;
      pins_o <= 3'h0;
      fast_rc_req_o <= 1'b0;
    end else begin
      wake_o <= '0;
      irq_o <= (src_i[2:0] == 3'h1);
      wake_o.gpio_events[0] <= (src_i[2:0] == 3'h2);
      wake_o.serial_start_bit <= (src_i[2:0] == 3'h3);
      wake_o.two_wire_addr_match <= (src_i[2:0] == 3'h4);
      wake_o.lowpower_timer_wake <= (src_i[2:0] == 3'h5);
      wake_o.calendar_alarm_a <= (src_i[2:0] == 3'h6);
      pins_o <= {3{src_i[2:0] == 3'h7}};
      fast_rc_req_o <= src_i[3];
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the low-power mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lpm_pkg::*;
;
  logic clk, arst_n, cpu_idle, mode_req, cal_keep, lprun_exit, rst_pin, wdg;
  logic irq, fast_rc_req, fast_rc, flash_ws, freq_err, wake_irq, cal_run;
  lpm_req_type   sel;
  logic [1:0]    range;
  logic [15:0]   khz;
  logic [3:0]    src;
  logic [2:0]    pins;
  lpm_wake_type  wake;
  lpm_state_type mode;
  lpm_osc_type   osc;
  lpm_dom_type   dom;
  logic          sb_rst;
  lpm_osc_type   osc_sw = 7'h7f;
  int            miscompares = 0;
  int            n_compared = 0;
  int            n_irq = 0;
  // Range, kHz, expected wait state, expected limit flag.
  localparam logic [19:0] RNG_TBL [10] = '{
    {2'h1, 16'h3e80, 2'b00}, {2'h1, 16'h3e81, 2'b10},
    {2'h1, 16'h7d00, 2'b10}, {2'h1, 16'h7d01, 2'b11},
    {2'h2, 16'h1f40, 2'b00}, {2'h2, 16'h1f41, 2'b10},
    {2'h2, 16'h3e80, 2'b10}, {2'h2, 16'h3e81, 2'b11},
    {2'h3, 16'h1068, 2'b00}, {2'h3, 16'h1069, 2'b01}};

  lpm_controller i_dut (
    .clk_i(clk), .arst_n_i(arst_n), .cpu_idle_i(cpu_idle),
    .mode_req_i(mode_req), .mode_sel_i(sel), .calendar_keep_i(cal_keep),
    .range_i(range), .cpu_khz_i(khz), .irq_pending_i(irq),
    .lprun_exit_i(lprun_exit), .osc_sw_i(osc_sw), .wake_i(wake),
    .wake_pins_i(pins), .reset_pin_i(rst_pin),
    .independent_watchdog_rst_i(wdg), .fast_rc_req_i(fast_rc_req),
    .mode_o(mode), .osc_en_o(osc), .dom_o(dom),
    .fast_rc_to_periph_o(fast_rc), .flash_ws_o(flash_ws),
    .freq_err_o(freq_err), .wake_irq_o(wake_irq), .standby_reset_o(sb_rst),
    .calendar_run_o(cal_run));
  lpm_periph i_periph (
    .clk_i(clk), .arst_n_i(arst_n), .src_i(src), .irq_o(irq),
    .wake_o(wake), .pins_o(pins), .fast_rc_req_o(fast_rc_req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (wake_irq === 1'b1) n_irq++;

  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic enter(input lpm_req_type s, input logic c);
    @(posedge clk);
    mode_req <= 1'b1;
    cpu_idle <= 1'b1;
    sel <= s;
    cal_keep <= c;
    @(posedge clk);
    mode_req <= 1'b0;
    cpu_idle <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // A limit that runs out is counted and ends the run at once.
  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (mode !== LPM_RUN) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        chk(32'(mode), 32'(LPM_RUN));
        close_out();
      end
    end
  endtask
  task automatic t_ranges();
    foreach (RNG_TBL[i]) begin
      @(posedge clk);
      {range, khz} <= RNG_TBL[i][19:2];
      repeat (500) @(posedge clk);
      #1;
      chk(32'(flash_ws), 32'(RNG_TBL[i][1]));
      chk(32'(freq_err), 32'(RNG_TBL[i][0]));
    end
  endtask
  task automatic t_refuse();
    @(posedge clk);
    mode_req <= 1'b1;
    sel <= LPM_REQ_STOP;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(mode), 32'(LPM_RUN));
    @(posedge clk);
    mode_req <= 1'b0;
    osc_sw <= '0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(osc), 32'h0);
    chk(32'(cal_run), 32'h0);
    @(posedge clk);
    osc_sw <= 7'h7f;
  endtask
  task automatic t_sleep(input lpm_req_type s, input int lim);
    enter(s, 1'b0);
    chk(32'(dom.cpu_clk), 32'h0);
    chk(32'(dom.regulator_lp), 32'(s == LPM_REQ_LPSLEEP));
    @(posedge clk);
    src <= 4'h1;
    wait_run(lim);
    chk({dom.cpu_clk, dom.regulator_lp}, 32'h2);
    @(posedge clk);
    src <= 4'h0;
  endtask
  task automatic t_lprun();
    @(posedge clk);
    khz <= 16'h0083;
    enter(LPM_REQ_LPRUN, 1'b0);
    chk(32'(mode), 32'(LPM_LPRUN));
    chk(32'(osc.fast_internal_rc), 32'h0);
    chk(32'(freq_err), 32'h0);
    @(posedge clk);
    khz <= 16'h0084;
    repeat (500) @(posedge clk);
    #1;
    chk(32'(freq_err), 32'h1);
    @(posedge clk);
    khz <= 16'h0083;
    lprun_exit <= 1'b1;
    wait_run(304);
    @(posedge clk);
    lprun_exit <= 1'b0;
  endtask
  task automatic t_stop(input logic c);
    int k;
    for (int s = 2; s <= 6; s++) begin
      enter(LPM_REQ_STOP, c);
      k = n_irq;
      chk(32'(mode), 32'(LPM_STOP));
      chk({osc.slow_crystal_osc, osc.slow_internal_rc}, {2{c}});
      chk(32'(cal_run), 32'h1);
      if (s == 3) begin
        @(posedge clk);
        src <= 4'h8;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(fast_rc), 32'h1);
        chk(32'(osc.fast_internal_rc), 32'h1);
        @(posedge clk);
        src <= 4'h0;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(fast_rc), 32'h0);
        chk(32'(osc.fast_internal_rc), 32'h0);
      end
      @(posedge clk);
      src <= 4'(s);
      // Without the calendar an alarm must not end Stop.
      if (s == 6 && !c) begin
        repeat (20) @(posedge clk);
        #1;
        chk(32'(mode), 32'(LPM_STOP));
        @(posedge clk);
        src <= 4'h2;
      end
      wait_run(504);
      chk(32'(n_irq - k), 32'h1);
      @(posedge clk);
      src <= 4'h0;
    end
  endtask
  task automatic t_stby(input logic c, input logic rp);
    @(posedge clk);
    src <= 4'h7;
    // The pins must be through the synchroniser before entry, or their
    // rise lands inside Standby and is a genuine wake edge.
    repeat (4) @(posedge clk);
    enter(LPM_REQ_STANDBY, c);
    chk(32'(mode), 32'(LPM_STANDBY));
    chk(32'(dom.core_power), 32'h0);
    chk(32'(cal_run), 32'h1);
    @(posedge clk);
    wdg <= 1'b1;
    rst_pin <= rp;
    // Pins high since before entry and the watchdog are both ignored.
    if (!c && !rp) begin
      repeat (20) @(posedge clk);
      #1;
      chk(32'(mode), 32'(LPM_STANDBY));
      @(posedge clk);
      src <= 4'h0;
      repeat (5) @(posedge clk);
      src <= 4'h7;
    end
    wait_run(6504);
    chk(32'(sb_rst), 32'h0);
    @(posedge clk);
    wdg <= 1'b0;
    rst_pin <= 1'b0;
    src <= 4'h0;
  endtask
  task automatic t_reset();
    enter(LPM_REQ_STOP, 1'b1);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({mode, osc, dom, cal_run}, {LPM_RUN, 7'h00, 5'h1b, 1'b1});
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(mode), 32'(LPM_RUN));
  endtask

  initial begin
    {arst_n, cpu_idle, mode_req, cal_keep, lprun_exit, rst_pin, wdg} = '0;
    sel = LPM_REQ_SLEEP;
    range = RANGE_3;
    khz = 16'h1068;
    src = 4'h0;
    repeat (20) @(posedge clk);
    #1;
    chk({mode, osc, dom}, {LPM_RUN, 7'h00, 5'h1b});
    @(posedge clk);
    arst_n <= 1'b1;
    t_ranges();
    t_refuse();
    t_sleep(LPM_REQ_SLEEP, 10);
    t_sleep(LPM_REQ_LPSLEEP, 11);
    t_lprun();
    t_stop(1'b1);
    t_stop(1'b0);
    t_stby(1'b0, 1'b0);
    t_stby(1'b1, 1'b0);
    t_stby(1'b0, 1'b1);
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
